// ==== src/ebtw_regs.vh ====
// register map, field positions and reset values of the external bus block
// assumes a 32-bit ahb-lite register window and byte addressing
`ifndef EBTW_REGS_VH
`define EBTW_REGS_VH
// register window: haddr[31:8] selects it, haddr[7:0] is the offset
`define EBTW_REG_BASE 24'h400080
`define EBTW_OFF_CTRL 8'h00
`define EBTW_OFF_PAGE 8'h04
`define EBTW_OFF_STAT 8'h08
`define EBTW_OFF_MASK 8'h0c
// bank n timing sets at 8'h10 + 8'h10*n: address +0, read +4, write +8
`define EBTW_SUB_ADDR 2'h0
`define EBTW_SUB_RD 2'h1
`define EBTW_SUB_WR 2'h2
// bus_control_set fields
`define EBTW_CTRL_BANK_EN 0
`define EBTW_CTRL_ITS 4
`define EBTW_CTRL_ALTERNATE_MAP_SELECT 5
`define EBTW_CTRL_NOIDLE 6
`define EBTW_CTRL_MODE 8
`define EBTW_CTRL_BL 12
`define EBTW_CTRL_NAND_EN 16
`define EBTW_CTRL_NAND_BANK 17
`define EBTW_CTRL_RST 19'h00000
// timing fields, 4 bits each
`define EBTW_T_SETUP 0
`define EBTW_T_STRB 4
`define EBTW_T_HOLD 8
`define EBTW_ATIM_RST 8'hff
`define EBTW_RWTIM_RST 12'hfff
`define EBTW_PAGE_ACC 0
`define EBTW_PAGE_EN 4
`define EBTW_PAGE_RST 5'h0f
// interrupt status bits
`define EBTW_IRQ_DONE 0
`define EBTW_IRQ_FAULT 1
`define EBTW_IRQ_REJECT 2
// address map
`define EBTW_CODE_LO 32'h12000000
`define EBTW_CODE_HI 32'h20000000
`endif

// ==== src/ebtw_top.v ====
// external parallel bus interface: ahb-lite slave, bank decode, width
// translation and per-state timing towards one shared external bus.
// assumes hclk drives both the ahb side and the external strobes.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ebtw_regs.vh"
module ebtw_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hmaster_dma,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // external bus pins
  output reg [27:0] ext_addr,
  output reg [15:0] ext_dout,
  output reg ext_dout_oe_n,
  input wire [15:0] ext_din,
  output reg [3:0] bank_chip_select_n,
  output reg read_en_n,
  output reg write_en_n,
  output reg [1:0] byte_lane_n,
  output reg addr_latch,
  // interrupt
  output reg irq
);
  localparam [11:0] S_IDLE = 12'h001;
  localparam [11:0] S_PREP = 12'h002;
  localparam [11:0] S_GAP = 12'h004;
  localparam [11:0] S_ASET = 12'h008;
  localparam [11:0] S_AHLD = 12'h010;
  localparam [11:0] S_RSET = 12'h020;
  localparam [11:0] S_RSTB = 12'h040;
  localparam [11:0] S_RHLD = 12'h080;
  localparam [11:0] S_WSET = 12'h100;
  localparam [11:0] S_WSTB = 12'h200;
  localparam [11:0] S_WHLD = 12'h400;
  localparam [11:0] S_ERR = 12'h800;

  // zero in a minimum-one field counts as one
  function [3:0] min1;
    input [3:0] v;
    begin
      min1 = (v == 4'h0) ? 4'h1 : v;
    end
  endfunction

  // address decode: {valid, code, bank, offset}
  function [31:0] dec;
    input [31:0] a;
    input alt;
    begin
      dec = 32'h0;
      if (a >= `EBTW_CODE_LO && a < `EBTW_CODE_HI)
      begin
        if (a[27:25] >= 3'h4)
          dec = {2'b11, 2'h3, 1'b0, a[26:0]};
        else
          dec = {2'b11, a[26:25] - 2'h1, 3'h0, a[24:0]};
      end
      else if (!alt && a[31:28] == 4'h8)
        dec = {2'b10, a[27:26], 2'h0, a[25:0]};
      else if (alt && a[31:30] == 2'b10)
        dec = {2'b10, a[29:28], a[27:0]};
    end
  endfunction

  // configuration registers
  reg [18:0] ctrl_q;
  reg [4:0] page_q;
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  reg [7:0] atim_q [0:3];
  reg [11:0] rtim_q [0:3];
  reg [11:0] wtim_q [0:3];
  // register write pending for the data phase
  reg wp_q;
  reg [7:0] woff_q;
  // transaction state
  reg [11:0] st_q;
  reg [11:0] st_d;
  reg [3:0] cnt_q;
  reg [1:0] pidx_q;
  reg [2:0] npc_q;
  reg wr_q;
  reg [1:0] size_q;
  reg [27:0] off_q;
  reg [1:0] bank_q;
  reg code_q;
  reg valid_q;
  reg dma_q;
  reg rmw_q;
  reg opwr_q;
  reg last_v_q;
  reg [1:0] last_bank_q;
  reg [31:0] rbuf_q;
  reg [31:0] rbuf_d;
  reg [31:0] wbuf_q;
  reg [15:0] rmwh_q;
  reg [2:0] stat_d;
  // external data synchroniser
  reg [15:0] din_s1_q;
  reg [15:0] din_s2_q;
  integer i;

  // effective settings of the addressed bank
  wire individual_timing_select = ctrl_q[`EBTW_CTRL_ITS];
  wire noidle = ctrl_q[`EBTW_CTRL_NOIDLE];
  wire [1:0] tsel = individual_timing_select ? bank_q : 2'h0;
  wire [7:0] at = atim_q[tsel];
  wire [11:0] rt = rtim_q[tsel];
  wire [11:0] wt = wtim_q[tsel];
  wire m16 = ctrl_q[`EBTW_CTRL_MODE + tsel];
  wire blf = ctrl_q[`EBTW_CTRL_BL + tsel];
  wire narrow = (size_q == 2'h0) && m16;
  wire nand_hit = ctrl_q[`EBTW_CTRL_NAND_EN] &&
    (ctrl_q[`EBTW_CTRL_NAND_BANK +: 2] == bank_q);
  wire fnand = wr_q && narrow && nand_hit;
  wire rej = !valid_q || (code_q && dma_q) ||
    !ctrl_q[`EBTW_CTRL_BANK_EN + bank_q];
  // ahb capture
  wire cap = hsel && htrans[1] && hready;
  wire rreg = (haddr[31:8] == `EBTW_REG_BASE);
  wire [31:0] dc = dec(haddr, ctrl_q[`EBTW_CTRL_ALTERNATE_MAP_SELECT]);
  // piece address: consecutive, incrementing from the low bytes
  wire [27:0] pa = m16 ? ({off_q[27:1], 1'b0} + {25'h0, pidx_q, 1'b0}) :
    (off_q + {26'h0, pidx_q});
  wire [7:0] wbyte = wbuf_q[{pa[1:0], 3'b000} +: 8];
  wire [7:0] nbyte = wbuf_q[{off_q[1:0], 3'b000} +: 8];
  wire [1:0] rsel = haddr[5:4] - 2'h1;

  // state length of the current state
  reg [3:0] dur;
  always @*
  begin
    case (st_q)
      S_ASET: dur = min1(at[`EBTW_T_SETUP +: 4]);
      S_AHLD: dur = at[`EBTW_T_STRB +: 4];
      S_RSET: dur = rt[`EBTW_T_SETUP +: 4];
      S_RSTB: dur = (page_q[`EBTW_PAGE_EN] && pidx_q != 2'h0) ?
        min1(page_q[`EBTW_PAGE_ACC +: 4]) :
        min1(rt[`EBTW_T_STRB +: 4]);
      S_RHLD: dur = rt[`EBTW_T_HOLD +: 4];
      S_WSET: dur = wt[`EBTW_T_SETUP +: 4];
      S_WSTB: dur = min1(wt[`EBTW_T_STRB +: 4]);
      S_WHLD: dur = wt[`EBTW_T_HOLD +: 4];
      default: dur = 4'h1;
    endcase
  end

  wire last = ({1'b0, cnt_q} + 5'h01) >= {1'b0, dur};
  // idle cycle before a transaction: always on a bank change
  wire gapn = last_v_q && (!noidle || last_bank_q != bank_q);
  wire [11:0] pstart = gapn ? S_GAP : S_ASET;
  wire [11:0] phase = opwr_q ?
    ((wt[`EBTW_T_SETUP +: 4] != 4'h0) ? S_WSET : S_WSTB) :
    ((rt[`EBTW_T_SETUP +: 4] != 4'h0) ? S_RSET : S_RSTB);
  wire more = rmw_q || ({1'b0, pidx_q} + 3'h1 < npc_q);
  // later pieces of one access stay in one bank, so only the idle setting matters
  wire [11:0] pend = more ? (noidle ? S_ASET : S_GAP) : S_IDLE;
  wire pdone = last && ((st_q == S_RSTB && rt[`EBTW_T_HOLD +: 4] == 4'h0) ||
    st_q == S_RHLD || (st_q == S_WSTB && wt[`EBTW_T_HOLD +: 4] == 4'h0) ||
    st_q == S_WHLD);

  // next state, zero-length states are stepped over
  always @*
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (cap && !rreg) st_d = S_PREP;
      S_PREP: st_d = (rej || fnand) ? S_ERR : pstart;
      S_GAP: st_d = S_ASET;
      S_ASET: if (last) st_d = (at[`EBTW_T_STRB +: 4] != 4'h0) ? S_AHLD : phase;
      S_AHLD: if (last) st_d = phase;
      S_RSET: if (last) st_d = S_RSTB;
      S_RSTB: if (last) st_d = pdone ? pend : S_RHLD;
      S_RHLD: if (last) st_d = pend;
      S_WSET: if (last) st_d = S_WSTB;
      S_WSTB: if (last) st_d = pdone ? pend : S_WHLD;
      S_WHLD: if (last) st_d = pend;
      S_ERR: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // read data lands in the lanes of its byte address
  always @*
  begin
    rbuf_d = rbuf_q;
    if (st_q == S_RSTB && last && !rmw_q)
    begin
      if (m16)
        rbuf_d[{pa[1], 4'h0} +: 16] = din_s2_q;
      else
        rbuf_d[{pa[1:0], 3'b000} +: 8] = din_s2_q[7:0];
    end
  end

  // sticky events, set wins over the clear of a status read
  wire rd_stat = cap && rreg && !hwrite && haddr[7:0] == `EBTW_OFF_STAT;
  wire ev_done = pdone && !more;
  wire ev_fault = (st_q == S_PREP) && fnand && !rej;
  wire ev_rej = (st_q == S_PREP) && rej;
  always @*
  begin
    stat_d = rd_stat ? 3'h0 : stat_q;
    stat_d[`EBTW_IRQ_DONE] = stat_d[`EBTW_IRQ_DONE] | ev_done;
    stat_d[`EBTW_IRQ_FAULT] = stat_d[`EBTW_IRQ_FAULT] | ev_fault;
    stat_d[`EBTW_IRQ_REJECT] = stat_d[`EBTW_IRQ_REJECT] | ev_rej;
  end

  // register read value for the address phase
  reg [31:0] rdv;
  always @*
  begin
    rdv = 32'h0;
    case (haddr[7:0])
      `EBTW_OFF_CTRL: rdv = {13'h0, ctrl_q};
      `EBTW_OFF_PAGE: rdv = {27'h0, page_q};
      `EBTW_OFF_STAT: rdv = {29'h0, stat_q};
      `EBTW_OFF_MASK: rdv = {29'h0, mask_q};
      default:
      begin
        if (haddr[7:4] >= 4'h1 && haddr[7:4] <= 4'h4)
        begin
          case (haddr[3:2])
            `EBTW_SUB_ADDR: rdv = {24'h0, atim_q[rsel[1:0]]};
            `EBTW_SUB_RD: rdv = {20'h0, rtim_q[rsel[1:0]]};
            `EBTW_SUB_WR: rdv = {20'h0, wtim_q[rsel[1:0]]};
            default: rdv = 32'h0;
          endcase
        end
      end
    endcase
  end

  // registers, bus handshake and transaction bookkeeping
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `EBTW_CTRL_RST;
      page_q <= `EBTW_PAGE_RST;
      for (i = 0; i < 4; i = i + 1)
      begin
        atim_q[i] <= `EBTW_ATIM_RST;
        rtim_q[i] <= `EBTW_RWTIM_RST;
        wtim_q[i] <= `EBTW_RWTIM_RST;
      end
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      irq <= 1'b0;
      wp_q <= 1'b0;
      woff_q <= 8'h00;
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      pidx_q <= 2'h0;
      npc_q <= 3'h1;
      wr_q <= 1'b0;
      size_q <= 2'h0;
      off_q <= 28'h0;
      bank_q <= 2'h0;
      code_q <= 1'b0;
      valid_q <= 1'b0;
      dma_q <= 1'b0;
      rmw_q <= 1'b0;
      opwr_q <= 1'b0;
      last_v_q <= 1'b0;
      last_bank_q <= 2'h0;
      rbuf_q <= 32'h0;
      wbuf_q <= 32'h0;
      rmwh_q <= 16'h0;
      din_s1_q <= 16'h0;
      din_s2_q <= 16'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      din_s1_q <= ext_din;
      din_s2_q <= din_s1_q;
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? 4'h0 : cnt_q + 4'h1;
      rbuf_q <= rbuf_d;
      wp_q <= cap && rreg && hwrite;
      if (cap)
      begin
        woff_q <= haddr[7:0];
        wr_q <= hwrite;
        size_q <= hsize[1:0];
        dma_q <= hmaster_dma;
        valid_q <= dc[31];
        code_q <= dc[30];
        bank_q <= dc[29:28];
        off_q <= dc[27:0];
        if (rreg && !hwrite)
          hrdata <= rdv;
        if (!rreg)
          hreadyout <= 1'b0;
      end
      // register writes in the data phase
      if (wp_q)
      begin
        case (woff_q)
          `EBTW_OFF_CTRL: ctrl_q <= hwdata[18:0];
          `EBTW_OFF_PAGE: page_q <= hwdata[4:0];
          `EBTW_OFF_MASK: mask_q <= hwdata[2:0];
          default:
          begin
            if (woff_q[7:4] >= 4'h1 && woff_q[7:4] <= 4'h4)
            begin
              case (woff_q[3:2])
                `EBTW_SUB_ADDR: atim_q[woff_q[5:4] - 2'h1] <= hwdata[7:0];
                `EBTW_SUB_RD: rtim_q[woff_q[5:4] - 2'h1] <= hwdata[11:0];
                `EBTW_SUB_WR: wtim_q[woff_q[5:4] - 2'h1] <= hwdata[11:0];
                default: ;
              endcase
            end
          end
        endcase
      end
      // translate the access into external pieces
      if (st_q == S_PREP)
      begin
        wbuf_q <= hwdata;
        rbuf_q <= 32'h0;
        pidx_q <= 2'h0;
        if (m16)
          npc_q <= (size_q == 2'h2) ? 3'h2 : 3'h1;
        else
          npc_q <= (size_q == 2'h2) ? 3'h4 : ((size_q == 2'h1) ? 3'h2 : 3'h1);
        rmw_q <= wr_q && narrow && !blf;
        opwr_q <= wr_q && !(narrow && !blf);
        if (rej || fnand)
          hresp <= 1'b1;
      end
      if (st_q == S_ERR)
        hreadyout <= 1'b1;
      else if (st_q == S_IDLE)
        hresp <= 1'b0;
      if (st_q == S_RSTB && last && rmw_q)
        rmwh_q <= din_s2_q;
      if (pdone)
      begin
        last_v_q <= 1'b1;
        last_bank_q <= bank_q;
        if (rmw_q)
        begin
          rmw_q <= 1'b0;
          opwr_q <= 1'b1;
        end
        else if (more)
          pidx_q <= pidx_q + 2'h1;
        else
        begin
          hreadyout <= 1'b1;
          hrdata <= rbuf_d;
        end
      end
    end
  end

  // pins follow the state one cycle later
  wire act = (st_q & (S_ASET | S_AHLD | S_RSET | S_RSTB | S_RHLD |
    S_WSET | S_WSTB | S_WHLD)) != 12'h0;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_addr <= 28'h0;
      ext_dout <= 16'h0;
      ext_dout_oe_n <= 1'b1;
      bank_chip_select_n <= 4'hf;
      read_en_n <= 1'b1;
      write_en_n <= 1'b1;
      byte_lane_n <= 2'b11;
      addr_latch <= 1'b0;
    end
    else
    begin
      ext_addr <= pa;
      bank_chip_select_n <= act ? ~(4'h1 << bank_q) : 4'hf;
      addr_latch <= (st_q == S_ASET);
      read_en_n <= (st_q != S_RSTB);
      write_en_n <= (st_q != S_WSTB);
      ext_dout_oe_n <= !(act && opwr_q);
      if (!m16)
        byte_lane_n <= 2'b10;
      else if (narrow && blf)
        byte_lane_n <= off_q[0] ? 2'b01 : 2'b10;
      else
        byte_lane_n <= 2'b00;
      if (!m16)
        ext_dout <= {8'h00, wbyte};
      else if (narrow && !blf)
        ext_dout <= off_q[0] ? {nbyte, rmwh_q[7:0]} : {rmwh_q[15:8], nbyte};
      else
        ext_dout <= wbuf_q[{pa[1], 4'h0} +: 16];
    end
  end
endmodule
`default_nettype wire

// ==== sim/ebtw_chk.sv ====
// port checker for the external bus block: strobes, chip selects, error replies
// assumes it is bound into ebtw_top and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module ebtw_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus reply
  input wire logic hreadyout,
  input wire logic hresp,
  // external pins
  input wire logic [3:0] bank_chip_select_n,
  input wire logic read_en_n,
  input wire logic write_en_n,
  input wire logic ext_dout_oe_n,
  input wire logic addr_latch
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a piece opens with address setup, then strobes
  sequence s_setup;
    $rose(addr_latch);
  endsequence
  sequence s_strobe;
    !read_en_n || !write_en_n;
  endsequence
  // piece shape and bank selection
  AST_STRB_AFTER_SETUP: assert property (s_setup |-> ##[1:64] s_strobe)
    else $error("no strobe after address setup");
  AST_CS_ONE_BANK: assert property ($countones(bank_chip_select_n) >= 3)
    else $error("more than one chip select");
  AST_STRB_HAS_CS: assert property (s_strobe |-> !(&bank_chip_select_n))
    else $error("strobe without chip select");
  AST_BANK_GAP: assert property ((!(&bank_chip_select_n) && bank_chip_select_n != $past(bank_chip_select_n))
    |-> (&$past(bank_chip_select_n)))
    else $error("bank change without idle cycle");
  AST_RW_EXCL: assert property (!(!read_en_n && !write_en_n))
    else $error("read and write strobes together");
  AST_DRIVE_WRITE: assert property (s_strobe |-> ext_dout_oe_n == write_en_n)
    else $error("data drive does not follow direction");
  AST_STRB_STALL: assert property (s_strobe |-> !$past(hreadyout))
    else $error("strobe while bus not stalled");
  // error replies start no external transaction and last two cycles
  AST_ERR_NO_TXN: assert property (hresp && !hreadyout |-> (&bank_chip_select_n) && read_en_n && write_en_n)
    else $error("error reply with external activity");
  AST_ERR_FIRST: assert property (hresp && !hreadyout |=> hresp && hreadyout)
    else $error("error reply lacks second cycle");
  AST_ERR_END: assert property (hresp && hreadyout |=> !(hresp && hreadyout))
    else $error("error reply too long");
endmodule
bind ebtw_top ebtw_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .bank_chip_select_n(bank_chip_select_n), .read_en_n(read_en_n), .write_en_n(write_en_n),
  .ext_dout_oe_n(ext_dout_oe_n), .addr_latch(addr_latch));
`default_nettype wire

// ==== sim/ebtw_mem.sv ====
// behavioural external 16-bit memories, one per bank, on the shared bus
// assumes active-low chip selects, strobes and lanes from ebtw_top
`timescale 1ns/10ps
`default_nettype none
module ebtw_mem (
  // bus from the block
  input wire logic hclk,
  input wire logic [3:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] lane_n,
  input wire logic [27:0] addr,
  input wire logic [15:0] dout,
  // read data back
  output logic [15:0] din
);
  logic [15:0] mem_q [0:3][0:15];
  logic [15:0] last_q = 16'h0000;
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  logic [1:0] bank;
  int pieces = 0;
  logic [31:0] last_bank = 32'hffffffff;
  // bank from the one low chip select
  assign bank = !cs_n[1] ? 2'h1 : !cs_n[2] ? 2'h2 : !cs_n[3] ? 2'h3 : 2'h0;
  // data only while selected and strobed, else a pattern that changes each cycle
  assign din = (!rd_n && !(&cs_n)) ? mem_q[bank][addr[4:1]] : ~last_q;
  // writes land per lane; each strobe start counts one piece
  always @(posedge hclk)
  begin
    last_q <= din;
    rd_q <= rd_n;
    wr_q <= wr_n;
    if (!wr_n && !(&cs_n) && !lane_n[0])
      mem_q[bank][addr[4:1]][7:0] <= dout[7:0];
    if (!wr_n && !(&cs_n) && !lane_n[1])
      mem_q[bank][addr[4:1]][15:8] <= dout[15:8];
    if ((rd_q && !rd_n) || (wr_q && !wr_n))
    begin
      pieces <= pieces + 1;
      last_bank <= {30'h0, bank};
    end
  end
endmodule
`default_nettype wire

// ==== sim/ebtw_tb_top.sv ====
// self-checking bench for the external bus block: ahb-lite master tasks
// assumes ebtw_top, the checker bind and the ebtw_mem partner
`timescale 1ns/10ps
`default_nettype none
module ebtw_tb_top;
  localparam logic [31:0] RB = 32'h40008000;
  localparam logic [31:0] DB = 32'h80000000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hmaster_dma = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, ext_dout_oe_n, read_en_n, write_en_n, addr_latch, irq;
  wire logic [27:0] ext_addr;
  wire logic [15:0] ext_dout, ext_din;
  wire logic [3:0] bank_chip_select_n;
  wire logic [1:0] byte_lane_n;
  logic [31:0] rdat;
  int failures = 0;
  int n_compared = 0;
  int p;
  logic [31:0] dadr [0:6] = '{32'h84000000, 32'h12000000, 32'h14000000, 32'h18000000,
    32'h1c000000, 32'h90000000, 32'hb0000000};
  int dbnk [0:6] = '{1, 0, 1, 3, 3, 1, 3};
  ebtw_top i_ebtw_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hmaster_dma(hmaster_dma),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_dout_oe_n(ext_dout_oe_n), .ext_din(ext_din), .bank_chip_select_n(bank_chip_select_n),
    .read_en_n(read_en_n), .write_en_n(write_en_n), .byte_lane_n(byte_lane_n), .addr_latch(addr_latch),
    .irq(irq));
  ebtw_mem i_mem (.hclk(hclk), .cs_n(bank_chip_select_n), .rd_n(read_en_n), .wr_n(write_en_n),
    .lane_n(byte_lane_n), .addr(ext_addr), .dout(ext_dout), .din(ext_din));
  // free-running clock
  initial
  begin
    forever #10 hclk = ~hclk;
  end
  // verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait for hready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 3000);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      end_sim();
    end
  endtask
  // one single ahb-lite transfer, response checked
  task automatic acc(input int wr, input logic [31:0] a, input logic [31:0] d, input int sz, input int dma,
                     input int eerr);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr[0];
    hsize <= sz[2:0];
    hmaster_dma <= dma[0];
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdat = hrdata;
    chk("resp", eerr, {31'h0, hresp});
    @(negedge hclk); // the memory model takes the last strobe at the ready edge
  endtask
  // irq level after it settles
  task automatic irq_is(input logic e);
    repeat (2) @(posedge hclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    acc(0, RB, 0, 2, 0, 0);
    chk("ctrl", 32'h0, rdat);
    acc(0, RB + 4, 0, 2, 0, 0);
    chk("page", 32'h0f, rdat);
    for (int b = 0; b < 4; b++)
    begin
      acc(0, RB + 16 + 16 * b, 0, 2, 0, 0);
      chk("atim", 32'hff, rdat);
      acc(0, RB + 20 + 16 * b, 0, 2, 0, 0);
      chk("rtim", 32'hfff, rdat);
      acc(0, RB + 24 + 16 * b, 0, 2, 0, 0);
      chk("wtim", 32'hfff, rdat);
    end
    acc(0, RB + 32'hfc, 0, 2, 0, 0);
    chk("unmapped", 32'h0, rdat);
    acc(0, DB, 0, 2, 0, 1);
    $display("test reset and disabled banks done");
    acc(1, RB + 16, 32'h00, 2, 0, 0);
    acc(1, RB + 20, 32'h060, 2, 0, 0);
    acc(1, RB + 24, 32'h000, 2, 0, 0);
    acc(1, RB, 32'h110f, 2, 0, 0);
    p = i_mem.pieces;
    acc(1, DB, 32'h12345678, 2, 0, 0);
    chk("pieces", p + 2, i_mem.pieces);
    chk("low word", 32'h5678, {16'h0, i_mem.mem_q[0][0]});
    chk("high word", 32'h1234, {16'h0, i_mem.mem_q[0][1]});
    acc(1, DB + 1, 32'h0000ab00, 0, 0, 0);
    acc(0, DB, 0, 2, 0, 0);
    chk("rd32", 32'h1234ab78, rdat);
    acc(0, DB + 2, 0, 0, 0, 0);
    chk("rd8", 32'h34, {24'h0, rdat[23:16]});
    acc(1, RB, 32'h010f, 2, 0, 0);
    p = i_mem.pieces;
    acc(1, DB, 32'h000000cd, 0, 0, 0);
    chk("rmw pieces", p + 2, i_mem.pieces);
    chk("rmw word", 32'habcd, {16'h0, i_mem.mem_q[0][0]});
    acc(0, DB + 3, 0, 0, 0, 0);
    chk("rd8 full", 32'h12, {24'h0, rdat[31:24]});
    acc(1, RB + 4, 32'h14, 2, 0, 0);
    acc(0, DB, 0, 2, 0, 0);
    chk("page rd32", 32'h1234abcd, rdat);
    $display("test width translation done");
    for (int i = 0; i < 7; i++)
    begin
      acc(1, RB, i > 4 ? 32'h016f : 32'h014f, 2, 0, 0);
      acc(1, dadr[i], 32'h00005a5a, 1, 0, 0);
      chk("bank", dbnk[i], i_mem.last_bank);
    end
    acc(1, RB, 32'h010f, 2, 0, 0);
    acc(1, 32'h12000000, 0, 2, 1, 1);
    acc(1, DB, 32'h00001111, 1, 1, 0);
    acc(1, RB, 32'h011f, 2, 0, 0);
    p = i_mem.pieces;
    acc(1, 32'h84000000, 32'hdeadbeef, 2, 0, 0);
    chk("byte pieces", p + 4, i_mem.pieces);
    $display("test bank decode done");
    acc(1, RB, 32'h0001010f, 2, 0, 0);
    acc(0, RB + 8, 0, 2, 0, 0);
    acc(1, RB + 12, 32'h2, 2, 0, 0);
    p = i_mem.pieces;
    acc(1, DB, 32'h11, 0, 0, 1);
    chk("nand pieces", p, i_mem.pieces);
    irq_is(1'b1);
    acc(0, RB + 8, 0, 2, 0, 0);
    chk("stat", 32'h2, rdat & 32'h2);
    irq_is(1'b0);
    acc(1, DB, 32'h7777, 1, 0, 0);
    irq_is(1'b0);
    acc(1, RB + 12, 32'h1, 2, 0, 0);
    irq_is(1'b1);
    acc(0, RB + 8, 0, 2, 0, 0);
    irq_is(1'b0);
    $display("test fault and interrupt done");
    end_sim();
  end
endmodule
`default_nettype wire
